/* verilog/sips_pkg.sv */
// shared constants, types and decode helper for the pair select block
package sips_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ==========================================================
  // register offsets
  localparam logic [7:0] CFG_OFFSET    = 8'h17; // pair select configuration
  localparam logic [7:0] MODE_OFFSET   = 8'h10; // input count mode
  localparam logic [7:0] STATUS_OFFSET = 8'h11; // effective routing, read only

  // ==========================================================
  // field layout of the registers
  localparam int CONV_COUNT   = 4;  // converters with a pair select bit
  localparam int CONV_SEL_MSB = 11; // converter 1 bit; converter k sits at 11-(k-1)
  localparam int PAIR_W       = 4;  // width of a pair number
  localparam int MODE_W       = 2;  // width of the mode field
  localparam int STAT_MODE16  = 4;  // status bit showing 16-input mode active

  // ==========================================================
  // reset values
  localparam logic [CONV_COUNT-1:0] SEL_RESET   = 4'h0;
  localparam logic [DATA_W-1:0]     RDATA_RESET = 16'h0000;

  // ==========================================================
  // input count modes
  typedef enum logic [1:0] {
    MODE_8IN  = 2'b00,
    MODE_16IN = 2'b01,
    MODE_32IN = 2'b10
  } sips_mode_t;

  localparam sips_mode_t MODE_RESET = MODE_16IN;

  // ==========================================================
  // address match used by both write and read decode
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    hit = (addr == offset);
  endfunction

endpackage

/* verilog/sips_route_sel.sv */
// one converter's input pair routing, registered
`timescale 1ns/1ps
module sips_route_sel #(
  parameter int CONV_INDEX = 0 // zero based converter number
) (
  input  wire logic                       clk,     // system clock
  input  wire logic                       resetn,  // async reset, active low
  input  wire logic                       mode16,  // 16-input mode active
  input  wire logic                       selHigh, // pick the higher pair
  output logic [sips_pkg::PAIR_W-1:0]     pairNum  // pair sampled by this converter
);

  // ==========================================================
  // pair numbers of the adjacent pairs served by this converter
  localparam logic [sips_pkg::PAIR_W-1:0] LOW_PAIR  = sips_pkg::PAIR_W'(2 * CONV_INDEX + 1);
  localparam logic [sips_pkg::PAIR_W-1:0] HIGH_PAIR = sips_pkg::PAIR_W'(2 * CONV_INDEX + 2);

  logic [sips_pkg::PAIR_W-1:0] next_pairNum;

  // select bit steers only in 16-input mode
  always_comb
  begin
    next_pairNum = (mode16 && selHigh) ? HIGH_PAIR : LOW_PAIR;
  end

  // registered routing output
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pairNum <= LOW_PAIR;
    else
      pairNum <= next_pairNum;
  end

endmodule

/* verilog/sips_rd_mux.sv */
// read data multiplexer, answer registered one cycle after the strobe
`timescale 1ns/1ps
module sips_rd_mux (
  input  wire logic                             clk,     // system clock
  input  wire logic                             resetn,  // async reset, active low
  input  wire logic                             rdEn,    // read strobe
  input  wire logic [sips_pkg::ADDR_W-1:0]      addr,    // register address
  input  wire logic [sips_pkg::DATA_W-1:0]      cfgWord, // configuration image
  input  wire logic [sips_pkg::DATA_W-1:0]      modeWord,// mode image
  input  wire logic [sips_pkg::DATA_W-1:0]      statWord,// status image
  output logic [sips_pkg::DATA_W-1:0]           rdata    // read data
);

  logic [sips_pkg::DATA_W-1:0] next_rdata;

  // pick the addressed word; unmapped or idle reads give zero
  always_comb
  begin
    next_rdata = sips_pkg::RDATA_RESET;
    if (rdEn)
    begin
      if (sips_pkg::hit(addr, sips_pkg::CFG_OFFSET))
        next_rdata = cfgWord;
      else if (sips_pkg::hit(addr, sips_pkg::MODE_OFFSET))
        next_rdata = modeWord;
      else if (sips_pkg::hit(addr, sips_pkg::STATUS_OFFSET))
        next_rdata = statWord;
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= sips_pkg::RDATA_RESET;
    else
      rdata <= next_rdata;
  end

endmodule

/* verilog/sips_top.sv */
// pair select register bank with per-converter input routing
`timescale 1ns/1ps

// Function
// R1 - 16-input mode: converter 1 takes pair 1 on bit 11 low, pair 2 high
// R2 - 16-input mode: converter 2 takes pair 3 on bit 10 low, pair 4 high
// R3 - 16-input mode: converter 3 takes pair 5 on bit 9 low, pair 6 high
// R4 - 16-input mode: converter 4 takes pair 7 on bit 8 low, pair 8 high
// R5 - select bits read/write, hold until rewritten or reset, steer only in 16-input mode
module sips_top (
  input  wire logic                         clk,       // 25 MHz system clock
  input  wire logic                         resetn,    // async reset, active low
  input  wire logic [sips_pkg::ADDR_W-1:0]  addr,      // register address
  input  wire logic [sips_pkg::DATA_W-1:0]  wdata,     // write data
  input  wire logic                         wrEn,      // write strobe
  input  wire logic                         rdEn,      // read strobe
  output logic [sips_pkg::DATA_W-1:0]       rdata,     // read data, cycle after strobe
  output logic [sips_pkg::PAIR_W-1:0]       convPair1, // pair sampled by converter_1
  output logic [sips_pkg::PAIR_W-1:0]       convPair2, // pair sampled by converter_2
  output logic [sips_pkg::PAIR_W-1:0]       convPair3, // pair sampled by converter_3
  output logic [sips_pkg::PAIR_W-1:0]       convPair4  // pair sampled by converter_4
);

  // ==========================================================
  // state
  logic [sips_pkg::CONV_COUNT-1:0] selHigh;  // bit k: converter k+1 takes higher pair
  sips_pkg::sips_mode_t            modeReg;  // input count mode
  logic                            mode16;   // 16-input mode active
  logic [sips_pkg::PAIR_W-1:0]     pairNum [sips_pkg::CONV_COUNT];
  logic [sips_pkg::DATA_W-1:0]     cfgWord;
  logic [sips_pkg::DATA_W-1:0]     modeWord;
  logic [sips_pkg::DATA_W-1:0]     statWord;
  logic                            cfgWr;
  logic                            modeWr;

  // ==========================================================
  // write decode
  assign cfgWr  = wrEn && sips_pkg::hit(addr, sips_pkg::CFG_OFFSET);
  assign modeWr = wrEn && sips_pkg::hit(addr, sips_pkg::MODE_OFFSET);
  assign mode16 = (modeReg == sips_pkg::MODE_16IN);

  // select bits: written as a group, held otherwise
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      selHigh <= sips_pkg::SEL_RESET; // [R1] [R2] [R3] [R4]
    else if (cfgWr)
    begin
      for (int k = 0; k < sips_pkg::CONV_COUNT; k++)
        selHigh[k] <= wdata[sips_pkg::CONV_SEL_MSB - k]; // [R5]
    end
  end

  // mode register; unknown codes fall back to 16-input mode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      modeReg <= sips_pkg::MODE_RESET;
    else if (modeWr)
    begin
      case (wdata[sips_pkg::MODE_W-1:0])
        sips_pkg::MODE_8IN:  modeReg <= sips_pkg::MODE_8IN;
        sips_pkg::MODE_32IN: modeReg <= sips_pkg::MODE_32IN;
        default:             modeReg <= sips_pkg::MODE_16IN;
      endcase
    end
  end

  // ==========================================================
  // read images; unused bits read zero
  always_comb
  begin
    cfgWord  = '0;
    modeWord = '0;
    statWord = '0;
    for (int k = 0; k < sips_pkg::CONV_COUNT; k++)
    begin
      cfgWord[sips_pkg::CONV_SEL_MSB - k] = selHigh[k]; // [R5]
      statWord[k]                         = selHigh[k] && mode16;
    end
    modeWord[sips_pkg::MODE_W-1:0] = modeReg;
    statWord[sips_pkg::STAT_MODE16] = mode16;
  end

  sips_rd_mux u_rd_mux (
    .clk      (clk),
    .resetn   (resetn),
    .rdEn     (rdEn),
    .addr     (addr),
    .cfgWord  (cfgWord),
    .modeWord (modeWord),
    .statWord (statWord),
    .rdata    (rdata)
  );

  // ==========================================================
  // per-converter routing
  generate
    for (genvar g = 0; g < sips_pkg::CONV_COUNT; g++)
    begin : g_route
      sips_route_sel #(
        .CONV_INDEX (g)
      ) u_route (
        .clk     (clk),
        .resetn  (resetn),
        .mode16  (mode16),  // [R5]
        .selHigh (selHigh[g]), // [R1] [R2] [R3] [R4]
        .pairNum (pairNum[g])
      );
    end
  endgenerate

  // routing outputs come straight from the route flops
  assign convPair1 = pairNum[0];
  assign convPair2 = pairNum[1];
  assign convPair3 = pairNum[2];
  assign convPair4 = pairNum[3];

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic pastValid;

  // marks cycles with a valid previous cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pastValid <= 1'b0;
    else
      pastValid <= 1'b1;
  end

  sequence s_cfg_write;
    cfgWr;
  endsequence

  sequence s_cfg_read;
    rdEn && sips_pkg::hit(addr, sips_pkg::CFG_OFFSET);
  endsequence

  // register strobes by target
  sequence s_mode_write;
    modeWr;
  endsequence

  sequence s_mode_read;
    rdEn && sips_pkg::hit(addr, sips_pkg::MODE_OFFSET);
  endsequence

  sequence s_stat_write;
    wrEn && sips_pkg::hit(addr, sips_pkg::STATUS_OFFSET);
  endsequence

  sequence s_stat_read;
    rdEn && sips_pkg::hit(addr, sips_pkg::STATUS_OFFSET);
  endsequence

  sequence s_unmapped_read;
    rdEn && !sips_pkg::hit(addr, sips_pkg::CFG_OFFSET) && !sips_pkg::hit(addr, sips_pkg::MODE_OFFSET)
    && !sips_pkg::hit(addr, sips_pkg::STATUS_OFFSET);
  endsequence

  // a select write followed by a cycle in 16-input mode
  sequence s_sel_applied;
    s_cfg_write ##1 mode16;
  endsequence

  a_conv1_route: assert property ( // [R1]
    pastValid |-> convPair1 == ($past(mode16 && selHigh[0]) ? 4'h2 : 4'h1))
    else $error("converter 1 routed to wrong pair");

  a_conv2_route: assert property ( // [R2]
    pastValid |-> convPair2 == ($past(mode16 && selHigh[1]) ? 4'h4 : 4'h3))
    else $error("converter 2 routed to wrong pair");

  a_conv3_route: assert property ( // [R3]
    pastValid |-> convPair3 == ($past(mode16 && selHigh[2]) ? 4'h6 : 4'h5))
    else $error("converter 3 routed to wrong pair");

  a_conv4_route: assert property ( // [R4]
    pastValid |-> convPair4 == ($past(mode16 && selHigh[3]) ? 4'h8 : 4'h7))
    else $error("converter 4 routed to wrong pair");

  a_cfg_write_takes: assert property ( // [R5]
    s_cfg_write |=> selHigh == {$past(wdata[8]), $past(wdata[9]), $past(wdata[10]), $past(wdata[11])})
    else $error("select bits did not take written value");

  a_cfg_holds_value: assert property ( // [R5]
    !cfgWr |=> $stable(selHigh))
    else $error("select bits changed without a write");

  a_cfg_read_back: assert property ( // [R5]
    s_cfg_write ##1 (!cfgWr and s_cfg_read) |=> rdata[11:8] == $past(wdata[11:8], 2))
    else $error("select bits read back wrong");

  a_other_mode_low: assert property ( // [R5]
    !mode16 ##1 !mode16 |-> convPair1 == 4'h1 && convPair4 == 4'h7)
    else $error("select bits steer outside 16-input mode");

  a_read_one_cycle: assert property (
    !rdEn |=> rdata == 16'h0000)
    else $error("read data stood beyond its cycle");

  // ==========================================================
  // assertions: reset and mode register

  // first cycle after release shows the reset image
  a_reset_defaults: assert property ( // [R1] [R2] [R3] [R4]
    !pastValid
    |-> selHigh == sips_pkg::SEL_RESET && modeReg == sips_pkg::MODE_RESET
        && convPair1 == 4'h1 && convPair2 == 4'h3 && convPair3 == 4'h5 && convPair4 == 4'h7)
    else $error("state not at reset values after release");

  // each mode code lands in the register
  a_mode_8in_take: assert property ( // [R5]
    s_mode_write ##0 (wdata[sips_pkg::MODE_W-1:0] == 2'h0)
    |=> modeReg == sips_pkg::MODE_8IN)
    else $error("8-input mode code not taken");

  a_mode_32in_take: assert property ( // [R5]
    s_mode_write ##0 (wdata[sips_pkg::MODE_W-1:0] == 2'h2)
    |=> modeReg == sips_pkg::MODE_32IN)
    else $error("32-input mode code not taken");

  a_mode_16in_take: assert property ( // [R5]
    s_mode_write ##0 wdata[0]
    |=> modeReg == sips_pkg::MODE_16IN)
    else $error("16-input mode code not taken");

  a_mode_holds_value: assert property ( // [R5]
    !modeWr
    |=> $stable(modeReg))
    else $error("mode changed without a write");

  // ==========================================================
  // assertions: read port

  // read data per target, one cycle after the strobe
  a_mode_read_back: assert property (
    s_mode_read
    |=> rdata[15:2] == 14'h0000 && rdata[1:0] == $past(modeReg))
    else $error("mode read back wrong");

  a_cfg_spare_zero: assert property ( // [R5]
    s_cfg_read
    |=> rdata[15:12] == 4'h0 && rdata[7:0] == 8'h00)
    else $error("unstored config bits read nonzero");

  a_stat_read_back: assert property ( // [R5]
    s_stat_read
    |=> rdata[15:5] == 11'h000 && rdata[4] == $past(mode16)
        && rdata[3:0] == ($past(selHigh) & {4{$past(mode16)}}))
    else $error("status read back wrong");

  // refused accesses leave no trace
  a_unmapped_read_zero: assert property (
    s_unmapped_read
    |=> rdata == sips_pkg::RDATA_RESET)
    else $error("unmapped read returned data");

  a_stat_write_ignored: assert property ( // [R5]
    s_stat_write
    |=> $stable(selHigh) && $stable(modeReg))
    else $error("write to status changed state");

  // ==========================================================
  // assertions: routing from the written word

  // pair follows the written bit two edges after the write
  a_conv1_from_write: assert property ( // [R1]
    s_sel_applied
    |=> convPair1 == ($past(wdata[11], 2) ? 4'h2 : 4'h1))
    else $error("converter 1 ignored its written select bit");

  a_conv2_from_write: assert property ( // [R2]
    s_sel_applied
    |=> convPair2 == ($past(wdata[10], 2) ? 4'h4 : 4'h3))
    else $error("converter 2 ignored its written select bit");

  a_conv3_from_write: assert property ( // [R3]
    s_sel_applied
    |=> convPair3 == ($past(wdata[9], 2) ? 4'h6 : 4'h5))
    else $error("converter 3 ignored its written select bit");

  a_conv4_from_write: assert property ( // [R4]
    s_sel_applied
    |=> convPair4 == ($past(wdata[8], 2) ? 4'h8 : 4'h7))
    else $error("converter 4 ignored its written select bit");

  // routing moves only when select or mode moves
  a_route_stable: assert property ( // [R5]
    $stable(selHigh) && $stable(mode16)
    |=> $stable(convPair1) && $stable(convPair2)
        && $stable(convPair3) && $stable(convPair4))
    else $error("routing changed with select and mode held");

  a_pairs_adjacent: assert property ( // [R1] [R2] [R3] [R4]
    convPair1 inside {4'h1, 4'h2} && convPair2 inside {4'h3, 4'h4}
    && convPair3 inside {4'h5, 4'h6} && convPair4 inside {4'h7, 4'h8})
    else $error("converter routed outside its pair");

  a_other_mode_mid: assert property ( // [R5]
    !mode16 ##1 !mode16
    |-> convPair2 == 4'h3 && convPair3 == 4'h5)
    else $error("middle converters steered outside 16-input mode");

endmodule

/* bench/sips_tb_top.sv */
// self-checking testbench for the pair select register bank
`timescale 1ns/1ps
module sips_tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic        wrEn   = 1'b0;
  logic        rdEn   = 1'b0;
  logic [7:0]  addr   = 8'h00;
  logic [15:0] wdata  = 16'h0000;
  logic [15:0] rdata;
  logic [3:0]  p1, p2, p3, p4;
  int          badCount = 0;
  int          nTests   = 0;

  // ==========================================================
  // clock, 40 ns period
  always #20 clk = ~clk;

  sips_top dut (
    .clk       (clk),    // system clock
    .resetn    (resetn), // async reset
    .addr      (addr),   // register address
    .wdata     (wdata),  // write data
    .wrEn      (wrEn),   // write strobe
    .rdEn      (rdEn),   // read strobe
    .rdata     (rdata),  // read data
    .convPair1 (p1),     // converter 1 pair
    .convPair2 (p2),     // converter 2 pair
    .convPair3 (p3),     // converter 3 pair
    .convPair4 (p4)      // converter 4 pair
  );

  // ==========================================================
  // helpers: compare, bus cycles, routing check
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      badCount++;
    end
  endtask

  // one-cycle write, entered and left at a rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wrEn  <= 1'b1;
    @(posedge clk);
    wrEn  <= 1'b0;
  endtask

  // one-cycle read; data in the next cycle only, zero after
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge clk);
    #1;
    chk("rdata idle", 16'h0000, rdata);
    @(posedge clk);
  endtask

  // sel[3] is converter 1; high pair only while 16-input mode is active
  task automatic rt(input logic [3:0] sel, input logic m16);
    logic [3:0] got [4];
    @(posedge clk);
    #1;
    got = '{p1, p2, p3, p4};
    for (int k = 0; k < 4; k++)
      chk($sformatf("convPair%0d", k + 1), 16'(2 * k + ((m16 && sel[3 - k]) ? 2 : 1)), 16'(got[k]));
    @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(8'h17, 16'h0000, "cfg after reset");
    rd(8'h10, 16'h0001, "mode after reset");
    rt(4'h0, 1'b1);
    $display("test reset done");
  endtask

  // each select bit alone, high pair then readback
  task automatic t_single();
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h17, 16'h0800 >> k);
      rt(4'h8 >> k, 1'b1);
      rd(8'h17, 16'h0800 >> k, "cfg single bit");
    end
    $display("test single bits done");
  endtask

  // masked write, unmapped and read-only writes leave bits alone
  task automatic t_hold();
    wr(8'h17, 16'hffff);
    rd(8'h17, 16'h0f00, "cfg masked");
    wr(8'h20, 16'h0000);
    @(posedge clk); // let the strobe fall before the next write
    wr(8'h11, 16'h0000);
    rd(8'h17, 16'h0f00, "cfg held");
    rd(8'h20, 16'h0000, "unmapped read");
    rt(4'hf, 1'b1);
    rd(8'h11, 16'h001f, "status all high");
    $display("test hold done");
  endtask

  // every mode code; steering only in 16-input mode
  task automatic t_mode();
    logic m16;
    for (int m = 0; m < 4; m++)
    begin
      m16 = (m == 1) || (m == 3);
      wr(8'h10, 16'(m));
      rt(4'hf, m16);
      rd(8'h10, (m == 3) ? 16'h0001 : 16'(m), "mode code");
      rd(8'h11, m16 ? 16'h001f : 16'h0000, "status by mode");
    end
    rd(8'h17, 16'h0f00, "cfg kept over mode");
    $display("test mode done");
  endtask

  // reset in mid-run clears the bits at once
  task automatic t_midreset();
    wr(8'h17, 16'h0500);
    rt(4'h5, 1'b1);
    resetn <= 1'b0;
    #1;
    chk("reset pairs", 16'h1357, {p1, p2, p3, p4});
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(8'h17, 16'h0000, "cfg after second reset");
    rt(4'h0, 1'b1);
    $display("test mid-run reset done");
  endtask

  // ==========================================================
  // verdict and run control
  task automatic conclude();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    chk("pairs in reset", 16'h1357, {p1, p2, p3, p4});
    chk("rdata in reset", 16'h0000, rdata);
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_single();
    t_hold();
    t_mode();
    t_midreset();
    conclude();
  end

  // watchdog well past the roughly 110 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    badCount++;
    conclude();
  end
endmodule
